/* File: shared/sbcra_regs.svh */
// Constants of the register-access link: frame layout, register map, masks and timing.
`ifndef SBCRA_REGS_SVH
`define SBCRA_REGS_SVH

// ************************************************************
// Frame layout
// ************************************************************
`define SBCRA_FRAME_BITS 5'h10
`define SBCRA_CNT_MAX    5'h11
`define SBCRA_ADDR_LAST  5'h07
`define SBCRA_DATA_FIRST 5'h08
`define SBCRA_RW_BIT     7
`define SBCRA_ADDR_MSB   6
`define SBCRA_DATA_LSB   8

// ************************************************************
// Register addresses (seven-bit word addresses)
// ************************************************************
`define SBCRA_A_MODE_SUPPLY   7'h01
`define SBCRA_A_HW_CFG        7'h02
`define SBCRA_A_WATCHDOG      7'h03
`define SBCRA_A_BUS_CFG_1     7'h04
`define SBCRA_A_BUS_CFG_2     7'h05
`define SBCRA_A_WAKE_PULL     7'h08
`define SBCRA_A_WAKE_FILTER   7'h09
`define SBCRA_A_TIMER1        7'h0C
`define SBCRA_A_TIMER2        7'h0D
`define SBCRA_A_SWITCH_SD     7'h10
`define SBCRA_A_HIGH_SIDE_1   7'h14
`define SBCRA_A_HIGH_SIDE_2   7'h15
`define SBCRA_A_GEN_IO        7'h17
`define SBCRA_A_DUTY_1        7'h18
`define SBCRA_A_DUTY_2        7'h19
`define SBCRA_A_MOD_FREQ      7'h1C
`define SBCRA_A_SYS_SCRATCH   7'h1E
`define SBCRA_A_SUPPLY_STS_2  7'h40
`define SBCRA_A_SUPPLY_STS_1  7'h41
`define SBCRA_A_THERMAL_STS   7'h42
`define SBCRA_A_DEVICE_STS    7'h43
`define SBCRA_A_BUS_STS_1     7'h44
`define SBCRA_A_WAKE_STS_1    7'h46
`define SBCRA_A_HS_OC_STS     7'h54
`define SBCRA_A_HS_OL_STS     7'h55
`define SBCRA_A_PRODUCT       7'h7E
`define SBCRA_PAGE_CTL        2'h0
`define SBCRA_PAGE_STS        2'h2

// ************************************************************
// Bit masks and reset values
// ************************************************************
`define SBCRA_MASK_ALL        8'hFF
`define SBCRA_MASK_NONE       8'h00
`define SBCRA_WMASK_HW_CFG    8'hFB
`define SBCRA_WMASK_WATCHDOG  8'hF7
`define SBCRA_WMASK_BUS_1     8'h03
`define SBCRA_WMASK_TIMER     8'h77
`define SBCRA_WMASK_SWITCH_SD 8'h30
`define SBCRA_HMASK_MODE_SUP  8'hFC
`define SBCRA_HMASK_HW_CFG    8'h20
`define SBCRA_KEEP_MODE_SUP   8'h23
`define SBCRA_KEEP_HW_CFG     8'hD9
`define SBCRA_POR_VALUE       8'h00
`define SBCRA_RESTART_VALUE   8'h00
// Arbitrary product value; it names no real part.
`define SBCRA_PRODUCT_ID      8'h5A

// ************************************************************
// Host link timing and register map
// ************************************************************
`define SBCRA_HALF_CYC   4'h7
`define SBCRA_WB_CMD     8'h00
`define SBCRA_WB_RDATA   8'h04
`define SBCRA_WB_STAT    8'h08
`define SBCRA_WB_IRQ_STS 8'h0C
`define SBCRA_WB_IRQ_MSK 8'h10

`endif

/* File: shared/sbcra_pkg.sv */
// Types shared by both ends of the register-access link.
package sbcra_pkg;

  typedef enum logic [4:0] {
    SBCRA_H_IDLE = 5'h01,
    SBCRA_H_LEAD = 5'h02,
    SBCRA_H_HIGH = 5'h04,
    SBCRA_H_LOW  = 5'h08,
    SBCRA_H_GAP  = 5'h10
  } sbcra_hstate_t;

  typedef struct packed {
    logic [1:0]       sclk_s;
    logic [1:0]       csn_s;
    logic [1:0]       mosi_s;
    logic             sclk_d;
    logic             csn_d;
    logic [4:0]       cnt;
    logic [15:0]      rx;
    logic [7:0]       tx_lo;
    logic [7:0]       tx_hi;
    logic             miso;
    logic [31:0][7:0] ctl;
    logic [31:0][7:0] sts;
  } sbcra_dev_st_t;

  typedef struct packed {
    sbcra_hstate_t state;
    logic [3:0]    div;
    logic [4:0]    cnt;
    logic [15:0]   tx;
    logic [15:0]   rx;
    logic [15:0]   rdata;
    logic          sclk;
    logic          csn;
    logic          mosi;
    logic [1:0]    miso_s;
    logic          irq_sts;
    logic          irq_msk;
    logic          ack;
    logic [31:0]   dat;
  } sbcra_host_st_t;

endpackage

/* File: shared/sbcra_spi_if.sv */
// Four-wire serial link between the host end and the device end.
`timescale 1ns/1ps
interface sbcra_spi_if;
  logic sclk;
  logic csn;
  logic mosi;
  logic miso;

  modport dev (
    input  sclk,
    input  csn,
    input  mosi,
    output miso
  );

  modport host (
    output sclk,
    output csn,
    output mosi,
    input  miso
  );
endinterface

/* File: rtl/sbcra_device.sv */
// Device end: serial register bank with control and status registers.
//
// Added by the designer: the Wishbone slave port of the host end.
`timescale 1ns/1ps
`include "sbcra_regs.svh"

// How it works
// - Frame is address byte then data byte.
// - Direction bit zero reads, nothing is stored.
// - Direction bit one stores the data byte.
// - Data bits sit at frame bits 8-15.
// - Reserved bits always read back as zero.
// - Host writes zeros into reserved positions.
// - Read-only bits ignore writes; rw bits store.
// - Hardware may update only rwh bits.
// - Reset or soft reset loads reset values.
// - Restart loads restart values, keeping don't-care bits.
// - Device never alters ordinary control bits itself.
// - Host changes ordinary control bits by writes.
// - One address selects one whole register byte.
// - Write frame shifts out the old content.
module sbcra_device (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Serial link
  sbcra_spi_if.dev         spi,
  // Chip-side control
  input  wire logic        soft_rst_i,
  input  wire logic        restart_i,
  // Hardware update of rwh control bits
  input  wire logic        hw_upd_stb_i,
  input  wire logic [6:0]  hw_upd_addr_i,
  input  wire logic [7:0]  hw_upd_data_i,
  input  wire logic [7:0]  hw_upd_mask_i,
  // Hardware events into status registers
  input  wire logic        sts_set_stb_i,
  input  wire logic [6:0]  sts_set_addr_i,
  input  wire logic [7:0]  sts_set_bits_i,
  // Control register contents and write-frame strobe to the chip
  output logic [31:0][7:0] ctl_regs_o,
  output logic             frame_wr_o
);

  // ************************************************************
  // Register map functions
  // ************************************************************
  // Writable bits of each control register; zero means unmapped.
  function automatic logic [7:0] ctl_wmask(input logic [6:0] a);
    logic [7:0] m;
    m = `SBCRA_MASK_NONE;
    case (a)
      `SBCRA_A_MODE_SUPPLY, `SBCRA_A_BUS_CFG_2, `SBCRA_A_WAKE_PULL,
      `SBCRA_A_WAKE_FILTER, `SBCRA_A_HIGH_SIDE_1, `SBCRA_A_HIGH_SIDE_2,
      `SBCRA_A_GEN_IO, `SBCRA_A_DUTY_1, `SBCRA_A_DUTY_2, `SBCRA_A_MOD_FREQ,
      `SBCRA_A_SYS_SCRATCH: m = `SBCRA_MASK_ALL;
      `SBCRA_A_HW_CFG:      m = `SBCRA_WMASK_HW_CFG;
      `SBCRA_A_WATCHDOG:    m = `SBCRA_WMASK_WATCHDOG;
      `SBCRA_A_BUS_CFG_1:   m = `SBCRA_WMASK_BUS_1;
      `SBCRA_A_TIMER1, `SBCRA_A_TIMER2: m = `SBCRA_WMASK_TIMER;
      `SBCRA_A_SWITCH_SD:   m = `SBCRA_WMASK_SWITCH_SD;
      default:              m = `SBCRA_MASK_NONE;
    endcase
    return m;
  endfunction

  // Bits that the chip's own logic may change.
  function automatic logic [7:0] ctl_hmask(input logic [6:0] a);
    logic [7:0] m;
    m = `SBCRA_MASK_NONE;
    case (a)
      `SBCRA_A_MODE_SUPPLY: m = `SBCRA_HMASK_MODE_SUP;
      `SBCRA_A_HW_CFG:      m = `SBCRA_HMASK_HW_CFG;
      default:              m = `SBCRA_MASK_NONE;
    endcase
    return m;
  endfunction

  // Bits that keep their value on restart.
  function automatic logic [7:0] ctl_keep(input logic [6:0] a);
    logic [7:0] m;
    m = `SBCRA_MASK_ALL;
    case (a)
      `SBCRA_A_MODE_SUPPLY: m = `SBCRA_KEEP_MODE_SUP;
      `SBCRA_A_HW_CFG:      m = `SBCRA_KEEP_HW_CFG;
      default:              m = `SBCRA_MASK_ALL;
    endcase
    return m;
  endfunction

  function automatic logic [7:0] sts_mask(input logic [6:0] a);
    logic [7:0] m;
    m = `SBCRA_MASK_NONE;
    case (a)
      `SBCRA_A_SUPPLY_STS_2, `SBCRA_A_SUPPLY_STS_1, `SBCRA_A_THERMAL_STS,
      `SBCRA_A_DEVICE_STS, `SBCRA_A_BUS_STS_1, `SBCRA_A_WAKE_STS_1,
      `SBCRA_A_HS_OC_STS, `SBCRA_A_HS_OL_STS: m = `SBCRA_MASK_ALL;
      default: m = `SBCRA_MASK_NONE;
    endcase
    return m;
  endfunction

  function automatic logic [6:0] idx_addr(input logic [1:0] page, input int i);
    return {page, i[4:0]};
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  sbcra_pkg::sbcra_dev_st_t st_r;
  sbcra_pkg::sbcra_dev_st_t st_nxt;

  logic [7:0] rd_val;
  logic [7:0] summary;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       csn_fall;
  logic       csn_rise;
  logic       wr_frame;
  logic [6:0] rx_addr;

  assign sclk_rise = st_r.sclk_s[1] & ~st_r.sclk_d & ~st_r.csn_s[1];
  assign sclk_fall = ~st_r.sclk_s[1] & st_r.sclk_d & ~st_r.csn_s[1];
  assign csn_fall  = ~st_r.csn_s[1] & st_r.csn_d;
  assign csn_rise  = st_r.csn_s[1] & ~st_r.csn_d;
  assign rx_addr   = st_r.rx[`SBCRA_ADDR_MSB:0];
  // A frame of any other length leaves every register as it was.
  assign wr_frame  = csn_rise & (st_r.cnt == `SBCRA_FRAME_BITS)
                   & st_r.rx[`SBCRA_RW_BIT];

  // ************************************************************
  // Read path
  // ************************************************************
  always_comb begin
    rd_val = `SBCRA_MASK_NONE;
    summary = `SBCRA_MASK_NONE;
    // The address has just completed, so rx holds all seven address bits.
    if (rx_addr[6:5] == `SBCRA_PAGE_CTL) begin
      rd_val = st_r.ctl[rx_addr[4:0]] & ctl_wmask(rx_addr);
    end else if (rx_addr[6:5] == `SBCRA_PAGE_STS) begin
      rd_val = st_r.sts[rx_addr[4:0]] & sts_mask(rx_addr);
    end else if (rx_addr == `SBCRA_A_PRODUCT) begin
      rd_val = `SBCRA_PRODUCT_ID;
    end
    for (int i = 0; i < 32; i++) begin
      summary = summary | st_r.sts[i];
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic [7:0] wdata;
    logic [7:0] wm;
    logic [7:0] hm;
    logic [4:0] ix;
    wdata = st_r.rx[15:8];
    wm = ctl_wmask(rx_addr);
    hm = ctl_hmask(hw_upd_addr_i) & hw_upd_mask_i;
    ix = rx_addr[4:0];
    st_nxt = st_r;
    // Synchronisers: the first stage feeds only the second.
    st_nxt.sclk_s = {st_r.sclk_s[0], spi.sclk};
    st_nxt.csn_s  = {st_r.csn_s[0], spi.csn};
    st_nxt.mosi_s = {st_r.mosi_s[0], spi.mosi};
    st_nxt.sclk_d = st_r.sclk_s[1];
    st_nxt.csn_d  = st_r.csn_s[1];

    if (csn_fall) begin
      st_nxt.cnt   = 5'h00;
      st_nxt.tx_lo = summary;
      st_nxt.tx_hi = `SBCRA_MASK_NONE;
      st_nxt.miso  = summary[0];
    end
    if (sclk_rise) begin
      st_nxt.rx[st_r.cnt[3:0]] = st_r.mosi_s[1];
      if (st_r.cnt != `SBCRA_CNT_MAX) begin
        st_nxt.cnt = st_r.cnt + 5'h01;
      end
    end
    // Old content is captured before any write of this frame lands.
    if (sclk_rise && st_r.cnt == `SBCRA_ADDR_LAST) begin
      st_nxt.tx_hi = rd_val;
    end
    if (sclk_fall) begin
      if (st_r.cnt < `SBCRA_DATA_FIRST) begin
        st_nxt.miso = st_r.tx_lo[st_r.cnt[2:0]];
      end else if (st_r.cnt < `SBCRA_FRAME_BITS) begin
        st_nxt.miso = st_r.tx_hi[st_r.cnt[2:0]];
      end else begin
        st_nxt.miso = 1'b0;
      end
    end

    // Only whole-register writes from the host; reserved bits stay zero.
    if (wr_frame && rx_addr[6:5] == `SBCRA_PAGE_CTL) begin
      st_nxt.ctl[ix] = (st_r.ctl[ix] & ~wm) | (wdata & wm);
    end
    // Writing a status register clears it; a same-cycle event still sets.
    if (wr_frame && rx_addr[6:5] == `SBCRA_PAGE_STS) begin
      st_nxt.sts[ix] = `SBCRA_MASK_NONE;
    end
    if (hw_upd_stb_i && hw_upd_addr_i[6:5] == `SBCRA_PAGE_CTL) begin
      st_nxt.ctl[hw_upd_addr_i[4:0]] = (st_nxt.ctl[hw_upd_addr_i[4:0]] & ~hm)
                                     | (hw_upd_data_i & hm);
    end
    if (sts_set_stb_i && sts_set_addr_i[6:5] == `SBCRA_PAGE_STS) begin
      st_nxt.sts[sts_set_addr_i[4:0]] = st_nxt.sts[sts_set_addr_i[4:0]]
                                      | (sts_set_bits_i & sts_mask(sts_set_addr_i));
    end

    if (restart_i) begin
      for (int i = 0; i < 32; i++) begin
        st_nxt.ctl[i] = ((st_r.ctl[i] & ctl_keep(idx_addr(`SBCRA_PAGE_CTL, i)))
                      | (`SBCRA_RESTART_VALUE & ~ctl_keep(idx_addr(`SBCRA_PAGE_CTL, i))))
                      & ctl_wmask(idx_addr(`SBCRA_PAGE_CTL, i));
      end
    end
    if (rst_i || soft_rst_i) begin
      for (int i = 0; i < 32; i++) begin
        st_nxt.ctl[i] = `SBCRA_POR_VALUE & ctl_wmask(idx_addr(`SBCRA_PAGE_CTL, i));
        st_nxt.sts[i] = `SBCRA_POR_VALUE;
      end
    end
    if (rst_i) begin
      st_nxt.sclk_s = 2'h0;
      st_nxt.csn_s  = 2'h3;
      st_nxt.mosi_s = 2'h0;
      st_nxt.sclk_d = 1'b0;
      st_nxt.csn_d  = 1'b1;
      st_nxt.cnt    = 5'h00;
      st_nxt.rx     = 16'h0000;
      st_nxt.tx_lo  = `SBCRA_MASK_NONE;
      st_nxt.tx_hi  = `SBCRA_MASK_NONE;
      st_nxt.miso   = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign spi.miso   = st_r.miso;
  assign ctl_regs_o = st_r.ctl;
  assign frame_wr_o = wr_frame;

endmodule

/* File: rtl/sbcra_host.sv */
// Host end: Wishbone-commanded serial master that issues one frame per command.
`timescale 1ns/1ps
`include "sbcra_regs.svh"

module sbcra_host (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Interrupt
  output logic             irq_o,
  // Serial link
  sbcra_spi_if.host        spi
);

  sbcra_pkg::sbcra_host_st_t st_r;
  sbcra_pkg::sbcra_host_st_t st_nxt;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic req;
    logic busy;
    logic half;
    req  = wb_cyc_i & wb_stb_i & ~st_r.ack;
    busy = st_r.state != sbcra_pkg::SBCRA_H_IDLE;
    half = st_r.div == `SBCRA_HALF_CYC;
    st_nxt = st_r;
    st_nxt.miso_s = {st_r.miso_s[0], spi.miso};
    st_nxt.ack = req;
    st_nxt.div = half ? 4'h0 : st_r.div + 4'h1;

    if (req) begin
      case (wb_adr_i)
        `SBCRA_WB_RDATA:   st_nxt.dat = {16'h0000, st_r.rdata};
        `SBCRA_WB_STAT:    st_nxt.dat = {31'h00000000, busy};
        `SBCRA_WB_IRQ_STS: st_nxt.dat = {31'h00000000, st_r.irq_sts};
        `SBCRA_WB_IRQ_MSK: st_nxt.dat = {31'h00000000, st_r.irq_msk};
        default:           st_nxt.dat = 32'h00000000;
      endcase
    end
    if (req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == `SBCRA_WB_IRQ_STS && wb_dat_i[0]) begin
        st_nxt.irq_sts = 1'b0;
      end
      if (wb_adr_i == `SBCRA_WB_IRQ_MSK) begin
        st_nxt.irq_msk = wb_dat_i[0];
      end
    end

    case (st_r.state)
      sbcra_pkg::SBCRA_H_IDLE: begin
        // A command while a frame runs is dropped; software polls busy first.
        if (req && wb_we_i && wb_adr_i == `SBCRA_WB_CMD && wb_sel_i[1:0] == 2'h3) begin
          // Software supplies zeros in reserved positions; reads send a zero data byte.
          st_nxt.tx = {wb_dat_i[7] ? wb_dat_i[15:8] : 8'h00, wb_dat_i[7:0]};
          st_nxt.mosi  = wb_dat_i[0];
          st_nxt.csn   = 1'b0;
          st_nxt.cnt   = 5'h00;
          st_nxt.div   = 4'h0;
          st_nxt.state = sbcra_pkg::SBCRA_H_LEAD;
        end
      end
      sbcra_pkg::SBCRA_H_LEAD, sbcra_pkg::SBCRA_H_LOW: begin
        if (half) begin
          st_nxt.sclk = 1'b1;
          st_nxt.rx[st_r.cnt[3:0]] = st_r.miso_s[1];
          st_nxt.state = sbcra_pkg::SBCRA_H_HIGH;
        end
      end
      sbcra_pkg::SBCRA_H_HIGH: begin
        if (half) begin
          st_nxt.sclk = 1'b0;
          st_nxt.cnt  = st_r.cnt + 5'h01;
          if (st_r.cnt == `SBCRA_FRAME_BITS - 5'h01) begin
            st_nxt.state = sbcra_pkg::SBCRA_H_GAP;
          end else begin
            st_nxt.mosi  = st_r.tx[st_r.cnt[3:0] + 4'h1];
            st_nxt.state = sbcra_pkg::SBCRA_H_LOW;
          end
        end
      end
      sbcra_pkg::SBCRA_H_GAP: begin
        // Chip select stays high a full half period so the far end sees it.
        if (half && !st_r.csn) begin
          st_nxt.csn = 1'b1;
        end else if (half) begin
          st_nxt.rdata   = st_r.rx;
          st_nxt.irq_sts = 1'b1;
          st_nxt.state   = sbcra_pkg::SBCRA_H_IDLE;
        end
      end
      default: st_nxt.state = sbcra_pkg::SBCRA_H_IDLE;
    endcase

    if (rst_i) begin
      st_nxt = '0;
      st_nxt.state = sbcra_pkg::SBCRA_H_IDLE;
      st_nxt.csn = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign wb_dat_o = st_r.dat;
  assign wb_ack_o = st_r.ack;
  assign irq_o    = st_r.irq_sts & st_r.irq_msk;
  assign spi.sclk = st_r.sclk;
  assign spi.csn  = st_r.csn;
  assign spi.mosi = st_r.mosi;

endmodule

/* File: verif/sbcra_properties.sv */
// Concurrent checks on the serial link that joins the host end and the device end.
`timescale 1ns/1ps

module sbcra_properties (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Serial link
  input  wire logic sclk,
  input  wire logic csn,
  input  wire logic mosi,
  input  wire logic miso
);
  // ************************************************************
  // Helper count of serial clock rises
  // ************************************************************
  logic [4:0] rise_cnt_r;
  logic       rst_d_r;

  default clocking cb @(posedge clk_i);
  endclocking
  // Link levels are unknown before reset, so the first edge after release is masked too.
  default disable iff (rst_i || rst_d_r);

  always_ff @(posedge clk_i) begin
    rst_d_r <= rst_i;
  end

  // Cleared while deselected, so a frame cut short cannot leak into the next one.
  always_ff @(posedge clk_i) begin
    if (rst_i || csn) begin
      rise_cnt_r <= 5'h00;
    end else if ($rose(sclk)) begin
      rise_cnt_r <= rise_cnt_r + 5'h01;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  a_idle_clock_low: assert property (csn |-> !sclk)
    else $error("serial clock high while deselected");
  a_frame_gap: assert property ($rose(csn) |-> csn [*8])
    else $error("deselect gap shorter than eight cycles");
  a_lead_time: assert property ($fell(csn) |-> !sclk [*8])
    else $error("first clock rise too early after select");
  a_half_period: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high phase not eight cycles");
  a_mosi_steady: assert property (sclk |-> $stable(mosi))
    else $error("host data moved while serial clock high");
  a_miso_steady: assert property (sclk |-> $stable(miso))
    else $error("device data moved while serial clock high");
  a_sixteen_bits: assert property ($rose(csn) |-> rise_cnt_r == 5'h10)
    else $error("frame did not carry sixteen clock rises");
  a_frame_length: assert property ($fell(csn) |-> ##[263:265] $rose(csn))
    else $error("frame select low for the wrong time");

  c_frame_end: cover property ($rose(csn));
  c_first_rise: cover property ($fell(csn) ##8 $rose(sclk));
  c_miso_high: cover property (sclk && miso);
endmodule

/* File: verif/sbc_spi_register_access_test.sv */
// Bench for both link ends: Wishbone commands, serial frames and chip-side events.
`timescale 1ns/1ps
`include "sbcra_regs.svh"

module sbc_spi_register_access_test;
  // ************************************************************
  // Signals
  // ************************************************************
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             wb_cyc_i = 1'b0;
  logic             wb_stb_i = 1'b0;
  logic             wb_we_i = 1'b0;
  logic [7:0]       wb_adr_i = 8'h00;
  logic [3:0]       wb_sel_i = 4'h0;
  logic [31:0]      wb_dat_i = 32'h00000000;
  logic [31:0]      wb_dat_o;
  logic             wb_ack_o;
  logic             irq_o;
  logic             soft_rst_i = 1'b0;
  logic             restart_i = 1'b0;
  logic             hw_upd_stb_i = 1'b0;
  logic [6:0]       hw_upd_addr_i = 7'h00;
  logic [7:0]       hw_upd_data_i = 8'h00;
  logic [7:0]       hw_upd_mask_i = 8'hFF;
  logic             sts_set_stb_i = 1'b0;
  logic [6:0]       sts_set_addr_i = 7'h00;
  logic [7:0]       sts_set_bits_i = 8'h00;
  logic [31:0][7:0] ctl;
  logic [31:0][7:0] ctl2;
  logic             fwr;
  logic             fwr2;
  int               err_total = 0;
  int               checked = 0;
  int               cycles = 0;
  int               wr2_count = 0;
  int               wr_count = 0;
  logic [31:0]      q;
  logic [15:0]      rx;
  logic [6:0]       ca [7] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h0C, 7'h10, 7'h1E};
  logic [7:0]       cm [7] = '{8'hFF, 8'hFB, 8'hF7, 8'h03, 8'h77, 8'h30, 8'hFF};
  int               nb [3] = '{8, 15, 17};

  sbcra_spi_if spi_a();
  sbcra_spi_if spi_b();

  sbcra_host sbcra_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .spi(spi_a.host));
  sbcra_device sbcra_device_i (.clk_i(clk_i), .rst_i(rst_i), .spi(spi_a.dev),
    .soft_rst_i(soft_rst_i), .restart_i(restart_i), .hw_upd_stb_i(hw_upd_stb_i),
    .hw_upd_addr_i(hw_upd_addr_i), .hw_upd_data_i(hw_upd_data_i),
    .hw_upd_mask_i(hw_upd_mask_i), .sts_set_stb_i(sts_set_stb_i),
    .sts_set_addr_i(sts_set_addr_i), .sts_set_bits_i(sts_set_bits_i),
    .ctl_regs_o(ctl), .frame_wr_o(fwr));
  // The second device faces the bench, which can cut frames short on purpose.
  sbcra_device sbcra_device_i2 (.clk_i(clk_i), .rst_i(rst_i), .spi(spi_b.dev),
    .soft_rst_i(soft_rst_i), .restart_i(restart_i), .hw_upd_stb_i(hw_upd_stb_i),
    .hw_upd_addr_i(hw_upd_addr_i), .hw_upd_data_i(hw_upd_data_i),
    .hw_upd_mask_i(hw_upd_mask_i), .sts_set_stb_i(sts_set_stb_i),
    .sts_set_addr_i(sts_set_addr_i), .sts_set_bits_i(sts_set_bits_i),
    .ctl_regs_o(ctl2), .frame_wr_o(fwr2));
  sbcra_properties sbcra_properties_i (.clk_i(clk_i), .rst_i(rst_i), .sclk(spi_a.sclk),
    .csn(spi_a.csn), .mosi(spi_a.mosi), .miso(spi_a.miso));

  always #10 clk_i = ~clk_i;

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    @(posedge clk_i);
    // No wait limit here: a missing answer is caught by the cycle ceiling.
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Issues one frame and waits for busy to drop; a stuck busy counts as a mismatch.
  task automatic frame(input logic w, input logic [6:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wb(1'b1, `SBCRA_WB_CMD, {16'h0000, d, w, a}, q);
    q = 32'h00000001;
    while (q[0] !== 1'b0 && n < 200) begin
      wb(1'b0, `SBCRA_WB_STAT, 32'h00000000, q);
      n++;
    end
    if (n >= 200) begin
      err_total++;
      end_sim();
    end
    wb(1'b0, `SBCRA_WB_RDATA, 32'h00000000, q);
    rx = q[15:0];
  endtask

  task automatic strobe(input int k);
    if (k == 0) soft_rst_i <= 1'b1;
    else if (k == 1) restart_i <= 1'b1;
    else if (k == 2) hw_upd_stb_i <= 1'b1;
    else sts_set_stb_i <= 1'b1;
    @(posedge clk_i);
    {soft_rst_i, restart_i, hw_upd_stb_i, sts_set_stb_i} <= 4'h0;
    repeat (2) @(posedge clk_i);
  endtask

  // Bench-made link clock of 160 ns, standing still outside the frame.
  task automatic raw(input int bits, input logic [15:0] v);
    spi_b.csn <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < bits; i++) begin
      spi_b.mosi <= v[i % 16];
      repeat (4) @(posedge clk_i);
      spi_b.sclk <= 1'b1;
      repeat (4) @(posedge clk_i);
      spi_b.sclk <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    spi_b.csn <= 1'b1;
    spi_b.mosi <= ~spi_b.mosi;
    repeat (12) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    if (fwr2 === 1'b1) wr2_count++;
    if (fwr === 1'b1) wr_count++;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      end_sim();
    end
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    spi_b.csn = 1'b1;
    spi_b.sclk = 1'b0;
    spi_b.mosi = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    wb(1'b0, `SBCRA_WB_STAT, 32'h00000000, q);
    chk("stat", q[7:0], 8'h00);
    wb(1'b0, 8'h14, 32'h00000000, q);
    chk("unmapped", q[7:0], 8'h00);
    foreach (ca[i]) begin
      frame(1'b1, ca[i], cm[i]);
      chk("old", rx[15:8], 8'h00);
      frame(1'b0, ca[i], 8'h3C);
      chk("rd", rx[15:8], cm[i]);
      frame(1'b0, ca[i], 8'h00);
      chk("kept", rx[15:8], cm[i]);
    end
    foreach (ca[i]) chk("map", ctl[ca[i][4:0]], cm[i]);
    frame(1'b1, `SBCRA_A_PRODUCT, 8'hA5);
    frame(1'b0, `SBCRA_A_PRODUCT, 8'h00);
    chk("ro", rx[15:8], `SBCRA_PRODUCT_ID);
    sts_set_addr_i <= `SBCRA_A_THERMAL_STS;
    sts_set_bits_i <= 8'h81;
    strobe(3);
    sts_set_addr_i <= `SBCRA_A_SUPPLY_STS_2;
    sts_set_bits_i <= 8'h02;
    strobe(3);
    frame(1'b0, `SBCRA_A_THERMAL_STS, 8'h00);
    chk("sts", rx[15:8], 8'h81);
    chk("sts_or", rx[7:0], 8'h83);
    frame(1'b1, `SBCRA_A_THERMAL_STS, 8'h00);
    frame(1'b0, `SBCRA_A_THERMAL_STS, 8'h00);
    chk("sts_clr", rx[15:8], 8'h00);
    chk("sts_left", rx[7:0], 8'h02);
    wb(1'b1, `SBCRA_WB_IRQ_STS, 32'h00000001, q);
    wb(1'b1, `SBCRA_WB_IRQ_MSK, 32'h00000001, q);
    chk("irq_clr", {7'h00, irq_o}, 8'h00);
    frame(1'b0, 7'h01, 8'h00);
    chk("irq_set", {7'h00, irq_o}, 8'h01);
    wb(1'b1, `SBCRA_WB_IRQ_STS, 32'h00000001, q);
    wb(1'b1, `SBCRA_WB_IRQ_MSK, 32'h00000000, q);
    frame(1'b0, 7'h01, 8'h00);
    chk("irq_mask", {7'h00, irq_o}, 8'h00);
    wb(1'b0, `SBCRA_WB_IRQ_STS, 32'h00000000, q);
    chk("irq_sts", q[7:0], 8'h01);
    strobe(0);
    foreach (ca[i]) chk("soft", ctl[ca[i][4:0]], 8'h00);
    frame(1'b0, `SBCRA_A_SUPPLY_STS_2, 8'h00);
    chk("soft_sts", rx[15:8], 8'h00);
    hw_upd_addr_i <= 7'h01;
    hw_upd_data_i <= 8'hFF;
    strobe(2);
    chk("hw_rwh", ctl[1], 8'hFC);
    hw_upd_addr_i <= 7'h03;
    strobe(2);
    chk("hw_plain", ctl[3], 8'h00);
    frame(1'b1, 7'h01, 8'hFF);
    frame(1'b1, 7'h02, 8'hFB);
    frame(1'b1, 7'h03, 8'hF7);
    strobe(1);
    chk("rst_ms", ctl[1], 8'h23);
    chk("rst_hw", ctl[2], 8'hD9);
    chk("rst_wd", ctl[3], 8'hF7);
    foreach (nb[i]) raw(nb[i], {8'h55, 1'b1, 7'h0C});
    chk("short", ctl2[12], 8'h00);
    chk("short_wr", wr2_count[7:0], 8'h00);
    raw(16, {8'h55, 1'b1, 7'h0C});
    chk("full", ctl2[12], 8'h55);
    raw(16, {8'hAA, 1'b0, 7'h0C});
    chk("rd_keep", ctl2[12], 8'h55);
    chk("full_wr", wr2_count[7:0], 8'h01);
    chk("wr", wr_count[7:0], 8'h0C);
    end_sim();
  end
endmodule
